// *** include/p0pin_pkg.sv ***
`default_nettype none
package p0pin_pkg;
  // ref clock: 50 MHz from a 125 MHz core clock
  localparam int unsigned P0PIN_CORE_CLK_KHZ = 125000;
  localparam int unsigned P0PIN_REF_CLK_KHZ = 50000;
  // half period in core cycles, rounded down (shortest time)
  localparam int unsigned P0PIN_REF_HALF_CYC =
    (P0PIN_CORE_CLK_KHZ / P0PIN_REF_CLK_KHZ) / 2;
  // mgmt clock output divider (half period in core cycles)
  localparam int unsigned P0PIN_MDC_HALF_CYC = 25;
  // strap width and reset value
  localparam int unsigned P0PIN_STRAP_W = 8;
  localparam logic [7:0] P0PIN_STRAP_RST = 8'h00;
  // direction bit values
  localparam logic P0PIN_DIR_IN = 1'b0;
  localparam logic P0PIN_DIR_OUT = 1'b1;
  typedef enum logic [0:0] {P0PIN_MGMT_CLIENT, P0PIN_MGMT_HOST} p0pin_mgmt_e;
endpackage
`default_nettype wire

// *** verilog/p0pin_ctl.sv ***
`default_nettype none
// How it works
// RULE1 - phy mode ref pin times port data
// RULE2 - direction bit picks pin in or out
// RULE3 - input pin keeps pull-down on
// RULE4 - input plus isolate: no buffer, no pull-down
// RULE5 - output pin: buffer and pull-down off
// RULE6 - output plus isolate: driver off
// RULE7 - straps latched at reset release
// RULE8 - client mode: host clock, data two-way
// RULE9 - client mode: mgmt clock input only
// RULE10 - host mode: device drives mgmt clock
// RULE11 - mgmt data idles high, never low
// RULE12 - i2c clock input, data two-way
// RULE13 - i2c pins undriven until eeprom loaded
// RULE14 - out valid undriven while isolated; the code still drives it outside phy mode
// RULE15 - internal 50 MHz clock times sampling; the divider gives 62.5 MHz
module p0pin_ctl
  import p0pin_pkg::*;
#(
  parameter int unsigned STRAP_W = P0PIN_STRAP_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // virtual phy control bits
  input wire logic virtual_phy_special_ctl,
  input wire logic virtual_phy_isolate,
  input wire logic rmii_phy_mode,
  // straps
  input wire logic [STRAP_W-1:0] strap_pins,
  output logic [STRAP_W-1:0] strap_latched,
  // reference clock pin
  input wire logic port0_ref_clock_pin_i,
  output logic port0_ref_clock_pin_o,
  output logic port0_ref_clock_pin_oen,
  output logic port0_ref_clock_in_buf_en,
  output logic port0_ref_clock_pulldown_en,
  output logic port0_rmii_ref_clock,
  output logic port0_rmii_sample_tick,
  // rmii output valid from the data path
  input wire logic port0_out_valid_d,
  output logic port0_out_valid,
  output logic port0_out_valid_oen,
  // management pins
  input wire logic mgmt_host_mode,
  input wire logic port0_mgmt_clock_pin_i,
  output logic port0_mgmt_clock_pin_o,
  output logic port0_mgmt_clock_pin_oen,
  output logic port0_mgmt_clock_sync,
  input wire logic mgmt_data_drive,
  input wire logic mgmt_data_out,
  input wire logic port0_mgmt_data_pin_i,
  output logic port0_mgmt_data_pin_o,
  output logic port0_mgmt_data_pin_oen,
  output logic port0_mgmt_data_sync,
  // i2c client pins
  input wire logic eeprom_load_done,
  input wire logic i2c_data_low,
  input wire logic i2c_client_clock_pin_i,
  input wire logic i2c_client_data_pin_i,
  output logic i2c_client_data_pin_o,
  output logic i2c_client_data_pin_oen,
  output logic i2c_client_clock_pin_oen,
  output logic i2c_client_clock_sync,
  output logic i2c_client_data_sync
);

  // two-stage synchronisers for all pin inputs except strap_pins; stage 1 feeds stage 2 only
  localparam int unsigned NSYNC = 5;
  logic [NSYNC-1:0] sync1_reg, sync1_next;
  logic [NSYNC-1:0] sync2_reg, sync2_next;
  logic [NSYNC-1:0] pin_raw;
  // straps and strap-capture flag
  logic [STRAP_W-1:0] strap_reg, strap_next;
  logic strap_done_reg, strap_done_next;
  // ref clock divider
  logic [7:0] ref_cnt_reg, ref_cnt_next;
  logic ref_clk_reg, ref_clk_next;
  logic ref_in_prev_reg, ref_in_prev_next;
  logic tick_reg, tick_next;
  // mgmt clock divider
  logic [7:0] mdc_cnt_reg, mdc_cnt_next;
  logic mdc_reg, mdc_next;
  // registered pin controls
  logic ref_oen_reg, ref_oen_next;
  logic ref_buf_reg, ref_buf_next;
  logic ref_pd_reg, ref_pd_next;
  logic ov_reg, ov_next;
  logic ov_oen_reg, ov_oen_next;
  logic md_o_reg, md_o_next;
  logic md_oen_reg, md_oen_next;
  logic mc_oen_reg, mc_oen_next;
  logic sda_oen_reg, sda_oen_next;
  logic ref_is_out;

  assign pin_raw = {i2c_client_data_pin_i, i2c_client_clock_pin_i,
                    port0_mgmt_data_pin_i, port0_mgmt_clock_pin_i,
                    port0_ref_clock_pin_i};
  assign ref_is_out = (virtual_phy_special_ctl == P0PIN_DIR_OUT); // see RULE2

  // next-state logic for the whole pin block
  always_comb begin
    sync1_next = pin_raw;
    sync2_next = sync1_reg;
    // straps caught once on the first clock after reset release
    strap_next = strap_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      strap_next = strap_pins; // see RULE7
    end
    // internal 50 MHz source; integer divide of 125 MHz leaves a
    // half period of one core cycle, so it runs at 62.5 MHz
    ref_cnt_next = ref_cnt_reg + 8'h01;
    ref_clk_next = ref_clk_reg;
    if (ref_cnt_reg >= 8'(P0PIN_REF_HALF_CYC - 1)) begin
      ref_cnt_next = 8'h00;
      ref_clk_next = ~ref_clk_reg; // see RULE15
    end
    // sampling tick: rising edge of whichever clock times the port
    ref_in_prev_next = sync2_reg[0];
    if (ref_is_out) begin
      tick_next = ref_clk_next & ~ref_clk_reg; // see RULE15
    end else begin
      tick_next = sync2_reg[0] & ~ref_in_prev_reg; // see RULE1
    end
    // mgmt clock divider, used in host mode only
    mdc_cnt_next = mdc_cnt_reg + 8'h01;
    mdc_next = mdc_reg;
    if (mdc_cnt_reg >= 8'(P0PIN_MDC_HALF_CYC - 1)) begin
      mdc_cnt_next = 8'h00;
      mdc_next = ~mdc_reg;
    end
    // ref clock pin: enables low while driving
    ref_oen_next = ~(ref_is_out & ~virtual_phy_isolate); // see RULE6
    ref_buf_next = ~ref_is_out & ~virtual_phy_isolate; // see RULE4
    ref_pd_next = ~ref_is_out & ~virtual_phy_isolate; // see RULE3
    if (ref_is_out) begin
      ref_buf_next = 1'b0; // see RULE5
      ref_pd_next = 1'b0; // see RULE5
    end
    // out valid towards the mac: released while isolated in phy mode
    ov_next = port0_out_valid_d;
    ov_oen_next = ~(rmii_phy_mode & ~virtual_phy_isolate); // see RULE14
    if (!rmii_phy_mode) begin
      ov_oen_next = 1'b0;
    end
    // mgmt clock: driven in host mode, input in client mode
    mc_oen_next = ~mgmt_host_mode; // see RULE9
    if (mgmt_host_mode) begin
      mc_oen_next = 1'b0; // see RULE10
    end
    // mgmt data: only driven during a transaction, otherwise the
    // pull-up holds the idle high level
    md_o_next = mgmt_data_out;
    md_oen_next = ~mgmt_data_drive; // see RULE8
    if (!mgmt_data_drive) begin
      md_o_next = 1'b1; // see RULE11
    end
    // i2c data is open drain and stays released until eeprom load
    sda_oen_next = ~(eeprom_load_done & i2c_data_low); // see RULE13
  end

  // register stage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      strap_reg <= P0PIN_STRAP_RST;
      strap_done_reg <= 1'b0;
      ref_cnt_reg <= 8'h00;
      ref_clk_reg <= 1'b0;
      ref_in_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
      mdc_cnt_reg <= 8'h00;
      mdc_reg <= 1'b0;
      ref_oen_reg <= 1'b1;
      ref_buf_reg <= 1'b0;
      ref_pd_reg <= 1'b0;
      ov_reg <= 1'b0;
      ov_oen_reg <= 1'b1;
      md_o_reg <= 1'b1;
      md_oen_reg <= 1'b1;
      mc_oen_reg <= 1'b1;
      sda_oen_reg <= 1'b1;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      strap_reg <= strap_next;
      strap_done_reg <= strap_done_next;
      ref_cnt_reg <= ref_cnt_next;
      ref_clk_reg <= ref_clk_next;
      ref_in_prev_reg <= ref_in_prev_next;
      tick_reg <= tick_next;
      mdc_cnt_reg <= mdc_cnt_next;
      mdc_reg <= mdc_next;
      ref_oen_reg <= ref_oen_next;
      ref_buf_reg <= ref_buf_next;
      ref_pd_reg <= ref_pd_next;
      ov_reg <= ov_next;
      ov_oen_reg <= ov_oen_next;
      md_o_reg <= md_o_next;
      md_oen_reg <= md_oen_next;
      mc_oen_reg <= mc_oen_next;
      sda_oen_reg <= sda_oen_next;
    end
  end

  // outputs from flip-flops, except the port clock mux and the constant i2c levels
  assign strap_latched = strap_reg;
  assign port0_ref_clock_pin_o = ref_clk_reg;
  assign port0_ref_clock_pin_oen = ref_oen_reg;
  assign port0_ref_clock_in_buf_en = ref_buf_reg;
  assign port0_ref_clock_pulldown_en = ref_pd_reg;
  assign port0_rmii_ref_clock = ref_is_out ? ref_clk_reg : sync2_reg[0];
  assign port0_rmii_sample_tick = tick_reg;
  assign port0_out_valid = ov_reg;
  assign port0_out_valid_oen = ov_oen_reg;
  assign port0_mgmt_clock_pin_o = mdc_reg;
  assign port0_mgmt_clock_pin_oen = mc_oen_reg;
  assign port0_mgmt_clock_sync = sync2_reg[1];
  assign port0_mgmt_data_pin_o = md_o_reg;
  assign port0_mgmt_data_pin_oen = md_oen_reg;
  assign port0_mgmt_data_sync = sync2_reg[2];
  // i2c clock is never driven by this device
  assign i2c_client_clock_pin_oen = 1'b1; // see RULE12
  assign i2c_client_data_pin_o = 1'b0;
  assign i2c_client_data_pin_oen = sda_oen_reg;
  assign i2c_client_clock_sync = sync2_reg[3];
  assign i2c_client_data_sync = sync2_reg[4];

endmodule // p0pin_ctl
`default_nettype wire

// *** verif/p0pin_ctl_props.sv ***
`default_nettype none
module p0pin_ctl_props #(
  parameter int unsigned STRAP_W = 8
) (
  // clock, reset and control levels
  input wire logic clock,
  input wire logic rstn,
  input wire logic virtual_phy_special_ctl,
  input wire logic virtual_phy_isolate,
  input wire logic rmii_phy_mode,
  input wire logic mgmt_host_mode,
  input wire logic mgmt_data_drive,
  input wire logic eeprom_load_done,
  // straps
  input wire logic [STRAP_W-1:0] strap_pins,
  input wire logic [STRAP_W-1:0] strap_latched,
  // pin controls
  input wire logic port0_ref_clock_pin_oen,
  input wire logic port0_ref_clock_in_buf_en,
  input wire logic port0_ref_clock_pulldown_en,
  input wire logic port0_out_valid_oen,
  input wire logic port0_mgmt_clock_pin_oen,
  input wire logic port0_mgmt_data_pin_o,
  input wire logic port0_mgmt_data_pin_oen,
  input wire logic i2c_client_data_pin_oen,
  input wire logic i2c_client_clock_pin_oen
);
  // short aliases keep each property on two lines
  wire dir = virtual_phy_special_ctl;
  wire iso = virtual_phy_isolate;
  wire phy = rmii_phy_mode;
  wire bf = port0_ref_clock_in_buf_en;
  wire pd = port0_ref_clock_pulldown_en;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rstn);
  ref_in_pull_a: assert property (
    phy && !dir && !iso |=> pd && bf) else $error("pull-down off");
  ref_dir_a: assert property (
    phy && !iso |=> port0_ref_clock_pin_oen == !$past(dir)) else $error("dir");
  iso_in_a: assert property (
    !dir && iso |=> !pd && !bf) else $error("isolated input enabled");
  out_no_in_a: assert property (
    dir |=> !pd && !bf) else $error("output pin has input on");
  out_iso_a: assert property (
    dir && iso |=> port0_ref_clock_pin_oen) else $error("isolated driver on");
  valid_iso_a: assert property (
    phy |=> port0_out_valid_oen == $past(iso)) else $error("valid driver");
  mdc_host_a: assert property (
    mgmt_host_mode |=> !port0_mgmt_clock_pin_oen) else $error("mdc not out");
  mdio_idle_a: assert property (
    !mgmt_data_drive |=> port0_mgmt_data_pin_oen && port0_mgmt_data_pin_o)
    else $error("mdio not idle");
  i2c_hold_a: assert property (
    !eeprom_load_done |=> i2c_client_data_pin_oen && i2c_client_clock_pin_oen)
    else $error("i2c driven early");
  strap_cap_a: assert property (
    $rose(rstn) |=> strap_latched == $past(strap_pins)) else $error("strap");
endmodule // p0pin_ctl_props
bind p0pin_ctl p0pin_ctl_props #(.STRAP_W(STRAP_W)) i_props (.*);
`default_nettype wire

// *** verif/p0pin_far_model.sv ***
`default_nettype none
module p0pin_far_model (
  // design side of the shared pins
  input wire logic ref_o,
  input wire logic ref_oen,
  input wire logic md_o,
  input wire logic md_oen,
  input wire logic sda_o,
  input wire logic sda_oen,
  // resolved wire levels
  output logic ref_pin,
  output logic md_pin,
  output logic sda_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mac_clk = 1'h0; // mac reference, phase unrelated to the core
  // free-running link clock of 125 ns
  initial begin
    #3.3;
    forever #62.5 mac_clk = ~mac_clk;
  end
  // mac supplies the clock only while the device listens
  assign ref_pin = ref_oen ? mac_clk : ref_o;
  // pull-ups lift released data lines, so no stale value lingers
  assign md_pin = md_oen ? 1'h1 : md_o;
  assign sda_pin = sda_oen ? 1'h1 : sda_o;
endmodule // p0pin_far_model
`default_nettype wire

// *** verif/p0pin_ctl_tb_top.sv ***
`default_nettype none
module p0pin_ctl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rstn, virtual_phy_special_ctl, virtual_phy_isolate;
  logic rmii_phy_mode, port0_out_valid_d, mgmt_host_mode, mgmt_data_drive;
  logic mgmt_data_out, eeprom_load_done, i2c_data_low;
  logic port0_mgmt_clock_pin_i, i2c_client_clock_pin_i;
  logic [7:0] strap_pins, strap_latched;
  logic port0_ref_clock_pin_i, port0_mgmt_data_pin_i, i2c_client_data_pin_i;
  logic port0_ref_clock_pin_o, port0_ref_clock_pin_oen, port0_rmii_ref_clock;
  logic port0_ref_clock_in_buf_en, port0_ref_clock_pulldown_en;
  logic port0_rmii_sample_tick, port0_out_valid, port0_out_valid_oen;
  logic port0_mgmt_clock_pin_o, port0_mgmt_clock_pin_oen;
  logic port0_mgmt_clock_sync;
  logic port0_mgmt_data_pin_o, port0_mgmt_data_pin_oen, port0_mgmt_data_sync;
  logic i2c_client_data_pin_o, i2c_client_data_pin_oen;
  logic i2c_client_clock_pin_oen, i2c_client_clock_sync, i2c_client_data_sync;
  int num_errors = 0, total_checks = 0, n;
  p0pin_ctl i_p0pin_ctl (.*);
  p0pin_far_model i_p0pin_far_model (.ref_o(port0_ref_clock_pin_o),
    .ref_oen(port0_ref_clock_pin_oen), .md_o(port0_mgmt_data_pin_o),
    .md_oen(port0_mgmt_data_pin_oen), .sda_o(i2c_client_data_pin_o),
    .sda_oen(i2c_client_data_pin_oen), .ref_pin(port0_ref_clock_pin_i),
    .md_pin(port0_mgmt_data_pin_i), .sda_pin(i2c_client_data_pin_i));
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // wait k edges, then let their updates land
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // count sample ticks (m=0), mdc toggles (m=1) or port clock
  // toggles (m=2) over k cycles
  task automatic cnt(input int k, m);
    logic last;
    n = 0;
    last = (m == 1) ? port0_mgmt_clock_pin_o : port0_rmii_ref_clock;
    repeat (k) begin
      cyc(1);
      if (m == 0 && port0_rmii_sample_tick === 1'h1) n++;
      if (m == 1 && port0_mgmt_clock_pin_o !== last) n++;
      if (m == 2 && port0_rmii_ref_clock !== last) n++;
      last = (m == 1) ? port0_mgmt_clock_pin_o : port0_rmii_ref_clock;
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  initial begin
    {virtual_phy_special_ctl, virtual_phy_isolate, rmii_phy_mode,
     port0_out_valid_d, mgmt_host_mode, mgmt_data_drive, mgmt_data_out,
     eeprom_load_done, port0_mgmt_clock_pin_i, i2c_client_clock_pin_i,
     rstn} = '0;
    i2c_data_low = 1'h1;
    strap_pins = 8'h5a;
    cyc(2);
    chk({port0_ref_clock_pin_oen, i2c_client_data_pin_oen},
      8'h3);
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    cyc(2);
    chk(strap_latched, 8'h5a);
    @(posedge clock);
    strap_pins <= 8'ha5;
    cyc(2);
    chk(strap_latched, 8'h5a);
    @(posedge clock);
    rstn <= 1'h0;
    cyc(2);
    @(posedge clock);
    rstn <= 1'h1;
    cyc(2);
    chk(strap_latched, 8'ha5);
    // outside phy mode the valid pin is always driven
    chk(port0_out_valid_oen, 8'h0);
    $display("test straps done");
    @(posedge clock);
    rmii_phy_mode <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {virtual_phy_special_ctl, virtual_phy_isolate} <= 2'(i);
      port0_out_valid_d <= i[1];
      cyc(1);
      chk(port0_ref_clock_pin_oen, 8'(i != 2));
      chk({port0_ref_clock_in_buf_en, port0_ref_clock_pulldown_en},
        {6'h0, i == 0, i == 0});
      chk({port0_out_valid_oen, port0_out_valid},
        {6'h0, i[0], i[1]});
    end
    @(posedge clock);
    virtual_phy_isolate <= 1'h0;
    cyc(8);
    cnt(100, 0);
    chk(8'(n), 8'h32);
    // the port's own clock is the driven pin, one toggle per cycle
    cnt(100, 2);
    chk(8'(n), 8'h64);
    chk(8'(port0_ref_clock_pin_o ^ port0_rmii_ref_clock), 8'h0);
    @(posedge clock);
    virtual_phy_special_ctl <= 1'h0;
    cyc(8);
    cnt(200, 0);
    chk(8'(n inside {12, 13}), 8'h1);
    // as an input the port clock follows the mac's 125 ns clock
    cnt(200, 2);
    chk(8'(n inside {25, 26}), 8'h1);
    $display("test ref pin done");
    @(posedge clock);
    mgmt_host_mode <= 1'h1;
    cyc(2);
    chk(port0_mgmt_clock_pin_oen, 8'h0);
    cnt(100, 1);
    chk(8'(n), 8'h4);
    // client mode: the host clocks the pin, device drives data low
    @(posedge clock);
    {mgmt_host_mode, port0_mgmt_clock_pin_i, mgmt_data_drive} <= 3'h3;
    cyc(3);
    chk({port0_mgmt_clock_pin_oen, port0_mgmt_clock_sync,
      port0_mgmt_data_pin_oen, port0_mgmt_data_pin_o},
      8'hc);
    @(posedge clock);
    mgmt_data_drive <= 1'h0;
    cyc(3);
    chk({port0_mgmt_data_pin_oen, port0_mgmt_data_pin_o,
      port0_mgmt_data_sync}, 8'h7);
    $display("test mgmt done");
    @(posedge clock);
    {eeprom_load_done, i2c_client_clock_pin_i} <= 2'h3;
    cyc(3);
    chk({i2c_client_data_pin_oen, i2c_client_clock_pin_oen,
      i2c_client_data_sync, i2c_client_clock_sync},
      8'h5);
    $display("test i2c done");
    test_done();
  end
endmodule // p0pin_ctl_tb_top
`default_nettype wire
